// *** tsr_defines.svh ***
// Register offsets, field positions, reset values and status codes of the slave receiver
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH
`define TSR_OFF_OWN   2'h0
`define TSR_OFF_CTL   2'h1
`define TSR_OFF_STS   2'h2
`define TSR_OFF_DATA  2'h3
`define TSR_CTL_RSHI  7
`define TSR_CTL_EN    6
`define TSR_CTL_STA   5
`define TSR_CTL_STP   4
`define TSR_CTL_FLAG  3
`define TSR_CTL_ACK   2
`define TSR_OWN_GCALL 0
`define TSR_RST_OWN   8'h00
`define TSR_RST_CTL   8'h00
`define TSR_RST_DATA  8'h00
`define TSR_STS_OWN   8'h60
`define TSR_STS_AOWN  8'h68
`define TSR_STS_GEN   8'h70
`define TSR_STS_AGEN  8'h78
`define TSR_STS_DOK   8'h80
`define TSR_STS_DNAK  8'h88
`define TSR_STS_GOK   8'h90
`define TSR_STS_GNAK  8'h98
`define TSR_STS_END   8'hA0
`define TSR_STS_NONE  8'hF8
`define TSR_LAST_BIT  4'h7
`endif

// *** tsr_pkg.sv ***
// Types of the slave receiver: bus request, pin drives, phases and module state
package tsr_pkg;
  typedef enum logic [2:0] {TSR_IDLE, TSR_ADDR, TSR_AACK, TSR_DATA, TSR_DACK, TSR_SKIP} tsr_phase_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } tsr_bus_req_t;
  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } tsr_pins_t;
  typedef struct packed {
    tsr_phase_t phase;
    logic       scl_s1, scl_s2, scl_d;
    logic       sda_s1, sda_s2, sda_d;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic       gcall;
    logic       do_ack;
    logic       arb;
    logic       busy;
    logic       sda_oe;
    logic       scl_oe;
    logic       start_go;
    logic [7:0] rdata;
    logic [7:0] own;
    logic [7:0] ctl;
    logic [7:0] status;
    logic [7:0] data;
  } tsr_state_t;
endpackage : tsr_pkg

// *** tsr_slave_rx.sv ***
// Slave receiver of the two-wire serial interface with its register port
`timescale 1ns/1ps
`include "tsr_defines.svh"
module tsr_slave_rx
  import tsr_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire tsr_bus_req_t bus_req,
  output logic [7:0]        bus_rdata,
  input  wire logic         scl_i,
  input  wire logic         sda_i,
  output tsr_pins_t         pins,
  input  wire logic         arb_lost,
  output logic              start_go
);

  localparam tsr_state_t TSR_RST = '{
    phase:  TSR_IDLE,
    scl_s1: 1'b1,
    scl_s2: 1'b1,
    scl_d:  1'b1,
    sda_s1: 1'b1,
    sda_s2: 1'b1,
    sda_d:  1'b1,
    shift:  8'h00,
    cnt:    4'h0,
    gcall:  1'b0,
    do_ack: 1'b0,
    arb:    1'b0,
    busy:   1'b0,
    sda_oe: 1'b0,
    scl_oe: 1'b0,
    start_go: 1'b0,
    rdata:  8'h00,
    own:    `TSR_RST_OWN,
    ctl:    `TSR_RST_CTL,
    status: `TSR_STS_NONE,
    data:   `TSR_RST_DATA
  };

  tsr_state_t s_r;
  tsr_state_t s_nxt;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       addressed;
  logic       en;
  logic       ack_en;
  logic       flag;
  logic [7:0] shifted;
  logic       own_hit;
  logic       gcall_hit;

  // Edges and bus conditions seen on the synchronised pins
  assign scl_rise  = s_r.scl_s2 & ~s_r.scl_d;
  assign scl_fall  = ~s_r.scl_s2 & s_r.scl_d;
  assign start_det = s_r.scl_s2 & s_r.scl_d & s_r.sda_d & ~s_r.sda_s2;
  assign stop_det  = s_r.scl_s2 & s_r.scl_d & ~s_r.sda_d & s_r.sda_s2;
  assign addressed = (s_r.phase == TSR_DATA) || (s_r.phase == TSR_DACK);
  assign en        = s_r.ctl[`TSR_CTL_EN];
  assign ack_en    = s_r.ctl[`TSR_CTL_ACK];
  assign flag      = s_r.ctl[`TSR_CTL_FLAG];
  assign shifted   = {s_r.shift[6:0], s_r.sda_s2};
  // Recognition uses the live enables, so setting ack enable resumes it at once
  assign own_hit   = ack_en && (shifted[7:1] == s_r.own[7:1]);
  assign gcall_hit = ack_en && s_r.own[`TSR_OWN_GCALL] && (shifted[7:1] == 7'h00);

  always_comb begin
    s_nxt          = s_r;
    s_nxt.scl_s1   = scl_i;
    s_nxt.scl_s2   = s_r.scl_s1;
    s_nxt.scl_d    = s_r.scl_s2;
    s_nxt.sda_s1   = sda_i;
    s_nxt.sda_s2   = s_r.sda_s1;
    s_nxt.sda_d    = s_r.sda_s2;
    s_nxt.rdata    = 8'h00;
    s_nxt.start_go = 1'b0;

    // Register writes; the flag only clears by writing zero
    if (bus_req.wr) begin
      case (bus_req.addr)
        `TSR_OFF_OWN: s_nxt.own = bus_req.wdata;
        `TSR_OFF_CTL: begin
          s_nxt.ctl = bus_req.wdata;
          s_nxt.ctl[`TSR_CTL_FLAG] = s_r.ctl[`TSR_CTL_FLAG] & bus_req.wdata[`TSR_CTL_FLAG];
        end
        `TSR_OFF_DATA: s_nxt.data = bus_req.wdata;
        default: ;
      endcase
    end

    if (bus_req.rd) begin
      case (bus_req.addr)
        `TSR_OFF_OWN:  s_nxt.rdata = s_r.own;
        `TSR_OFF_CTL:  s_nxt.rdata = s_r.ctl;
        `TSR_OFF_STS:  s_nxt.rdata = s_r.status;
        `TSR_OFF_DATA: s_nxt.rdata = s_r.data;
        default:       s_nxt.rdata = 8'h00;
      endcase
    end

    if (arb_lost) begin
      s_nxt.arb = 1'b1;
    end
    if (start_det) begin
      s_nxt.busy = 1'b1;
    end
    if (stop_det) begin
      s_nxt.busy = 1'b0;
    end

    case (s_r.phase)
      TSR_IDLE: ;
      TSR_ADDR: begin
        if (scl_rise) begin
          s_nxt.shift = shifted;
          s_nxt.cnt   = s_r.cnt + 4'h1;
          if (s_r.cnt == `TSR_LAST_BIT) begin
            s_nxt.cnt = 4'h0;
            // Read direction belongs to the transmit side; this block stays off the bus then
            if (!shifted[0] && (own_hit || gcall_hit)) begin
              s_nxt.gcall  = gcall_hit && !own_hit;
              s_nxt.do_ack = 1'b1;
              s_nxt.phase  = TSR_AACK;
            end else begin
              s_nxt.phase = TSR_SKIP;
            end
          end
        end
      end
      TSR_DATA: begin
        if (scl_rise) begin
          s_nxt.shift = shifted;
          s_nxt.cnt   = s_r.cnt + 4'h1;
          if (s_r.cnt == `TSR_LAST_BIT) begin
            s_nxt.cnt    = 4'h0;
            s_nxt.data   = shifted;
            s_nxt.do_ack = ack_en;
            s_nxt.phase  = TSR_DACK;
          end
        end
      end
      TSR_AACK,
      TSR_DACK: begin
        // Stage 0 waits the fall after bit 8, stage 1 the ack clock rise, stage 2 its fall
        if (scl_fall && s_r.cnt == 4'h0) begin
          s_nxt.sda_oe = s_r.do_ack;
          s_nxt.cnt    = 4'h1;
        end else if (scl_rise && s_r.cnt == 4'h1) begin
          s_nxt.cnt = 4'h2;
        end else if (scl_fall && s_r.cnt == 4'h2) begin
          s_nxt.sda_oe = 1'b0;
          s_nxt.cnt    = 4'h0;
          s_nxt.ctl[`TSR_CTL_FLAG] = 1'b1;
          if (s_r.phase == TSR_AACK) begin
            s_nxt.phase = TSR_DATA;
            s_nxt.arb   = 1'b0;
            if (s_r.gcall) begin
              s_nxt.status = s_r.arb ? `TSR_STS_AGEN : `TSR_STS_GEN;
            end else begin
              s_nxt.status = s_r.arb ? `TSR_STS_AOWN : `TSR_STS_OWN;
            end
          end else if (s_r.do_ack) begin
            s_nxt.phase  = TSR_DATA;
            s_nxt.status = s_r.gcall ? `TSR_STS_GOK : `TSR_STS_DOK;
          end else begin
            s_nxt.phase  = TSR_IDLE;
            s_nxt.status = s_r.gcall ? `TSR_STS_GNAK : `TSR_STS_DNAK;
          end
        end
      end
      TSR_SKIP: ;
      default: s_nxt.phase = TSR_IDLE;
    endcase

    // Bus conditions override any phase
    if (start_det) begin
      if (addressed) begin
        s_nxt.ctl[`TSR_CTL_FLAG] = 1'b1;
        s_nxt.status = `TSR_STS_END;
      end
      s_nxt.phase  = TSR_ADDR;
      s_nxt.cnt    = 4'h0;
      s_nxt.sda_oe = 1'b0;
    end
    if (stop_det) begin
      if (addressed) begin
        s_nxt.ctl[`TSR_CTL_FLAG] = 1'b1;
        s_nxt.status = `TSR_STS_END;
      end
      s_nxt.phase  = TSR_IDLE;
      s_nxt.cnt    = 4'h0;
      s_nxt.arb    = 1'b0;
      s_nxt.sda_oe = 1'b0;
    end

    // A pending start request goes out once the bus is free and nothing waits on software
    if (en && s_r.ctl[`TSR_CTL_STA] && !flag && !s_r.busy && !addressed && s_r.phase != TSR_AACK) begin
      s_nxt.start_go = 1'b1;
      s_nxt.ctl[`TSR_CTL_STA] = 1'b0;
    end

    if (!en) begin
      s_nxt.phase  = TSR_IDLE;
      s_nxt.cnt    = 4'h0;
      s_nxt.sda_oe = 1'b0;
    end

    // Clock is only pulled once it is already low, so no short high pulse is cut
    s_nxt.scl_oe = en && s_nxt.ctl[`TSR_CTL_FLAG] && (s_r.scl_oe || !s_r.scl_s2);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_r <= TSR_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus_rdata   = s_r.rdata;
  assign pins.scl_o  = 1'b0;
  assign pins.scl_oe = s_r.scl_oe;
  assign pins.sda_o  = 1'b0;
  assign pins.sda_oe = s_r.sda_oe;
  assign start_go    = s_r.start_go;

  default clocking tsr_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  AST_SCL_HOLD:
    assert property ((en && flag && !s_r.scl_s2) |=> (pins.scl_oe || !flag))
    else $error("clock not held low while flag set");

  AST_SCL_FREE:
    assert property (pins.scl_oe |-> flag)
    else $error("clock held low without flag");

  AST_FLAG_CODE:
    assert property ($rose(flag) |-> s_r.status inside {`TSR_STS_OWN, `TSR_STS_AOWN, `TSR_STS_GEN,
                     `TSR_STS_AGEN, `TSR_STS_DOK, `TSR_STS_DNAK, `TSR_STS_GOK, `TSR_STS_GNAK, `TSR_STS_END})
    else $error("flag raised with invalid status");

  AST_ACK_EN:
    assert property ((s_r.phase == TSR_ADDR && scl_rise && s_r.cnt == `TSR_LAST_BIT && !ack_en && !start_det
                      && !stop_det) |=> s_r.phase != TSR_AACK)
    else $error("address acknowledged with ack disabled");

  AST_ACK_DRIVE:
    assert property ($rose(pins.sda_oe) |-> s_r.do_ack)
    else $error("data line driven without acknowledge");

  AST_NACK:
    assert property ((s_r.phase == TSR_DATA && scl_rise && s_r.cnt == `TSR_LAST_BIT && !ack_en)
                     |=> (!pins.sda_oe)[*4])
    else $error("acknowledge driven with ack disabled");

  AST_GCALL_OFF:
    assert property (($rose(flag) && s_r.status inside {`TSR_STS_GEN, `TSR_STS_AGEN}) |-> s_r.own[`TSR_OWN_GCALL])
    else $error("general call answered while disabled");

  AST_ARB:
    assert property (($rose(flag) && s_r.status inside {`TSR_STS_AOWN, `TSR_STS_AGEN}) |-> $past(s_r.arb))
    else $error("arbitration status without arbitration loss");

  AST_NACK_LEAVE:
    assert property (($rose(flag) && s_r.status inside {`TSR_STS_DNAK, `TSR_STS_GNAK}) |-> !addressed)
    else $error("still addressed after not-acknowledge");

  AST_DATA_REG:
    assert property (($rose(flag) && s_r.status == `TSR_STS_DOK) |-> s_r.data == s_r.shift)
    else $error("received byte not in data register");

  AST_STOP_END:
    assert property ((stop_det && addressed && en) |=> (flag && s_r.status == `TSR_STS_END && s_r.phase == TSR_IDLE))
    else $error("stop while addressed not reported");

  AST_START_GO:
    assert property (start_go |-> (!$past(s_r.busy) && $past(en) && !$past(flag)))
    else $error("start issued while bus busy");

endmodule : tsr_slave_rx

// *** tsr_master_model.sv ***
// Bus master transmitter model driving the two open-drain lines
`timescale 1ns/1ps
module tsr_master_model (
  input  wire logic scl_line,
  input  wire logic sda_line,
  output logic      scl_low,
  output logic      sda_low
);
  localparam int HALF = 40;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Release the clock, wait out stretching, sample, then pull low
  task automatic scl_pulse(output logic s);
    #HALF;
    scl_low = 1'b0;
    wait (scl_line === 1'b1);
    #HALF;
    s = sda_line;
    scl_low = 1'b1;
    #10;
  endtask : scl_pulse
  task automatic bus_start;
    sda_low = 1'b1;
    #HALF;
    scl_low = 1'b1;
    #10;
  endtask : bus_start
  task automatic bus_stop;
    sda_low = 1'b1;
    #HALF;
    scl_low = 1'b0;
    wait (scl_line === 1'b1);
    #HALF;
    sda_low = 1'b0;
    #HALF;
  endtask : bus_stop
  // Eight bits MSB first, then the acknowledge slot with SDA released
  task automatic send_byte(input logic [7:0] b, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      scl_pulse(s);
    end
    sda_low = 1'b0;
    scl_pulse(nack);
  endtask : send_byte
endmodule : tsr_master_model

// *** tb.sv ***
// Self-checking bench of the slave receiver: registers and bus frames
`timescale 1ns/1ps
`include "tsr_defines.svh"
module tb import tsr_pkg::*;;
  localparam logic [7:0] ON    = (8'h01 << `TSR_CTL_EN) | (8'h01 << `TSR_CTL_ACK);
  localparam logic [7:0] NOACK = ON & ~(8'h01 << `TSR_CTL_ACK);
  localparam logic [7:0] ME    = 8'h54;
  logic         sys_clk;
  logic         rst_n;
  tsr_bus_req_t bus_req;
  logic [7:0]   bus_rdata;
  tsr_pins_t    pins;
  logic         arb_lost;
  logic         start_go;
  logic         scl_low;
  logic         sda_low;
  logic         scl_line;
  logic         sda_line;
  logic         go_seen = 1'b0;
  logic         nack;
  logic [7:0]   rv;
  int           fail_count = 0;
  int           compares = 0;
  int           cycles = 0;
  // Open-drain lines with pull-ups
  assign scl_line = ~(scl_low | pins.scl_oe);
  assign sda_line = ~(sda_low | pins.sda_oe);
  tsr_slave_rx i_tsr_slave_rx (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .scl_i(scl_line), .sda_i(sda_line), .pins(pins), .arb_lost(arb_lost), .start_go(start_go));
  tsr_master_model i_tsr_master_model (.scl_line(scl_line), .sda_line(sda_line), .scl_low(scl_low),
    .sda_low(sda_low));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (start_go === 1'b1) go_seen <= 1'b1;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask : reg_rd
  task automatic sts(input logic [7:0] e);
    reg_rd(`TSR_OFF_STS, rv);
    chk("status", rv, e);
  endtask : sts
  task automatic xfer(input logic st, input logic [7:0] b, input logic exp);
    if (st) i_tsr_master_model.bus_start();
    i_tsr_master_model.send_byte(b, nack);
    chk("nack", {7'h00, nack}, {7'h00, exp});
    repeat (6) @(posedge sys_clk);
  endtask : xfer
  task automatic stop;
    i_tsr_master_model.bus_stop();
    repeat (6) @(posedge sys_clk);
  endtask : stop
  task automatic arb_pulse;
    @(posedge sys_clk) arb_lost <= 1'b1;
    @(posedge sys_clk) arb_lost <= 1'b0;
  endtask : arb_pulse
  initial begin
    rst_n    = 1'b0;
    bus_req  = '0;
    arb_lost = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    reg_rd(`TSR_OFF_OWN, rv);
    chk("own", rv, `TSR_RST_OWN);
    reg_rd(`TSR_OFF_CTL, rv);
    chk("ctl", rv, `TSR_RST_CTL);
    reg_wr(`TSR_OFF_STS, 8'h12);
    sts(`TSR_STS_NONE);
    $display("test reset_values done");
    reg_wr(`TSR_OFF_OWN, ME | 8'h01);
    reg_wr(`TSR_OFF_CTL, ON);
    xfer(1'b1, ME | 8'h01, 1'b1);
    stop();
    xfer(1'b1, ME + 8'h02, 1'b1);
    stop();
    xfer(1'b1, ME, 1'b0);
    chk("scl_hold", {7'h00, pins.scl_oe}, 8'h01);
    sts(`TSR_STS_OWN);
    reg_wr(`TSR_OFF_CTL, ON);
    xfer(1'b0, 8'hA5, 1'b0);
    sts(`TSR_STS_DOK);
    reg_rd(`TSR_OFF_DATA, rv);
    chk("data", rv, 8'hA5);
    reg_wr(`TSR_OFF_CTL, NOACK);
    xfer(1'b0, 8'h3C, 1'b1);
    sts(`TSR_STS_DNAK);
    reg_wr(`TSR_OFF_CTL, ON | (8'h01 << `TSR_CTL_STA));
    repeat (20) @(posedge sys_clk);
    chk("early_start", {7'h00, go_seen}, 8'h00);
    stop();
    repeat (20) @(posedge sys_clk);
    chk("start_go", {7'h00, go_seen}, 8'h01);
    reg_rd(`TSR_OFF_CTL, rv);
    chk("ctl", rv, ON);
    $display("test own_address done");
    reg_wr(`TSR_OFF_CTL, NOACK);
    xfer(1'b1, ME, 1'b1);
    stop();
    reg_wr(`TSR_OFF_CTL, ON);
    xfer(1'b1, ME, 1'b0);
    reg_wr(`TSR_OFF_CTL, ON);
    stop();
    sts(`TSR_STS_END);
    reg_wr(`TSR_OFF_CTL, ON);
    $display("test ack_enable done");
    reg_wr(`TSR_OFF_OWN, ME);
    xfer(1'b1, 8'h00, 1'b1);
    stop();
    reg_wr(`TSR_OFF_OWN, ME | 8'h01);
    xfer(1'b1, 8'h00, 1'b0);
    sts(`TSR_STS_GEN);
    reg_wr(`TSR_OFF_CTL, ON);
    xfer(1'b0, 8'h5A, 1'b0);
    sts(`TSR_STS_GOK);
    reg_wr(`TSR_OFF_CTL, NOACK);
    xfer(1'b0, 8'hC3, 1'b1);
    sts(`TSR_STS_GNAK);
    reg_rd(`TSR_OFF_DATA, rv);
    chk("data", rv, 8'hC3);
    reg_wr(`TSR_OFF_CTL, ON);
    stop();
    reg_rd(`TSR_OFF_CTL, rv);
    chk("ctl", rv, ON);
    $display("test general_call done");
    arb_pulse();
    xfer(1'b1, ME, 1'b0);
    sts(`TSR_STS_AOWN);
    reg_wr(`TSR_OFF_CTL, ON);
    stop();
    sts(`TSR_STS_END);
    reg_wr(`TSR_OFF_CTL, ON);
    arb_pulse();
    xfer(1'b1, 8'h00, 1'b0);
    sts(`TSR_STS_AGEN);
    reg_wr(`TSR_OFF_CTL, ON);
    stop();
    reg_wr(`TSR_OFF_CTL, ON);
    $display("test arbitration done");
    report_and_stop();
  end
endmodule : tb
